//--- smap_servo_monitor_aux.v
// object bank of monitor positions and the software and fault reset commands
`timescale 1ns/10ps
`default_nettype none
`include "smap_regs.vh"
// overview of the bank:
// - monitor objects are read-only; a write to one answers with an error
//   and leaves every register as it was
// - the load position objects only follow the encoder while rotation
//   mode is selected; outside it they keep their reset value or the last tracked value, so a
//   host that maps them cyclically sees a frozen word, not noise
// - the two command objects are one-shot: a write of one is judged in the
//   following cycle against the drive state of that cycle, answered by an
//   action or a refused pulse, and the object then reads zero again
// - a command write of zero is legal and does nothing
// - a restart only raises a request toward the drive; the drive's own
//   init logic does the re-run, this bank keeps its registers meanwhile
// - the access port answers every request one cycle later with an ack;
//   there are no wait states, so requests may follow back to back
module smap_servo_monitor_aux (
  input wire clk_sys,
  input wire rst,
  // object dictionary access port
  input wire objWrite,
  input wire objRead,
  input wire [7:0] objIndex,
  input wire [31:0] objWriteData,
  output reg [31:0] objReadData,
  output reg objAck,
  output reg objError,
  // drive state from the rest of the servo
  input wire servoOn,
  input wire driveOperational,
  input wire [15:0] positionMode,
  input wire [15:0] storageSetting,
  input wire faultPresent,
  input wire [1:0] faultClass,
  input wire faultNonResettable,
  input wire [31:0] absPositionHigh,
  input wire [31:0] loadPositionLow,
  input wire [31:0] loadPositionHigh,
  input wire [31:0] loadPositionRef,
  input wire parameter_integrity_fault,
  input wire [15:0] badParamGroup,
  input wire [15:0] badParamOffset,
  // actions toward the drive
  output wire restartRequest,
  output reg faultDisplayClear,
  output reg faultDisplayed,
  output reg restartRefused,
  output reg faultClearRefused
);
  wire rotationMode; // rotation mode selects the load position objects
  wire [31:0] heldLoadLow; // latched load position low word
  wire [31:0] heldLoadHigh; // latched load position high word
  wire [31:0] heldLoadRef; // latched load position in reference units
  reg [15:0] restartCmd; // stored software restart object value
  reg [15:0] faultClearCmd; // stored fault clear object value
  reg restartTrigger; // one-cycle accept of a restart
  reg [15:0] heldBadGroup; // group of the corrupt parameter
  reg [15:0] heldBadOffset; // offset of the corrupt parameter
  reg writeOk; // combinational write legality
  reg isReadOnly; // index names a monitor object or is unmapped
  reg isMapped; // index is known
  wire restartAllowed; // all restart conditions met
  wire faultClearAllowed; // current fault may be cleared now
  wire servoIsOff; // servo switched off, restart may proceed
  wire classOneLockout; // non-resettable class 1 fault present
  wire storageIdle; // no nonvolatile storage operation running
  wire isWarning; // present fault is only a class 3 warning
  wire isClassOneTwo; // present fault is of class 1 or class 2
  reg [31:0] next_readData; // read mux result, registered with the ack
  assign rotationMode = (positionMode == `SMAP_MODE_ROTATION);
  // only while rotation mode is set do the load positions track
  smap_mon_hold #(.WIDTH(32), .RESET_VALUE(`SMAP_RST_LOAD_POS_LOW)) uLoadLow (
    .clk_sys(clk_sys),
    .rst(rst),
    .gate(rotationMode),
    .liveValue(loadPositionLow),
    .heldValue(heldLoadLow)
  );
  smap_mon_hold #(.WIDTH(32), .RESET_VALUE(32'h00000000)) uLoadHigh (
    .clk_sys(clk_sys),
    .rst(rst),
    .gate(rotationMode),
    .liveValue(loadPositionHigh),
    .heldValue(heldLoadHigh)
  );
  smap_mon_hold #(.WIDTH(32), .RESET_VALUE(32'h00000000)) uLoadRef (
    .clk_sys(clk_sys),
    .rst(rst),
    .gate(rotationMode),
    .liveValue(loadPositionRef),
    .heldValue(heldLoadRef)
  );
  // restart pulse lasts a few cycles so slower init logic sees it
  smap_pulse_gen #(.LENGTH(`SMAP_RESTART_PULSE_CYCLES)) uRestart (
    .clk_sys(clk_sys),
    .rst(rst),
    .trigger(restartTrigger),
    .pulseOut(restartRequest)
  );
  // restart is blocked while the servo is on
  assign servoIsOff = !servoOn;
  // only a non-resettable class 1 fault locks restart out
  assign classOneLockout = faultPresent && faultNonResettable
    && (faultClass == `SMAP_CLASS_ONE);
  // a restart mid-write could leave storage half written, so wait for idle
  assign storageIdle = (storageSetting != `SMAP_STORE_BUSY);
  // all three conditions together, judged in the cycle after the write
  assign restartAllowed = servoIsOff && !classOneLockout && storageIdle;
  // warnings may be cleared whatever the drive is doing
  assign isWarning = (faultClass == `SMAP_CLASS_WARN);
  // real faults need the drive stopped first
  assign isClassOneTwo = (faultClass == `SMAP_CLASS_ONE) || (faultClass == `SMAP_CLASS_TWO);
  // non-resettable faults are never cleared, whatever the class
  assign faultClearAllowed = faultPresent && !faultNonResettable
    && (isWarning || (isClassOneTwo && !driveOperational));
  // decode of index kinds and value range
  always @*
  begin
    isMapped = 1'b1;
    isReadOnly = 1'b1;
    case (objIndex)
      `SMAP_OFS_RESTART_CMD, `SMAP_OFS_FAULT_CLEAR_CMD: isReadOnly = 1'b0;
      `SMAP_OFS_ENTRY_COUNT, `SMAP_OFS_ABS_POS_HIGH, `SMAP_OFS_LOAD_POS_LOW,
      `SMAP_OFS_LOAD_POS_HIGH, `SMAP_OFS_LOAD_POS_REF, `SMAP_OFS_BAD_GROUP,
      `SMAP_OFS_BAD_OFFSET: isReadOnly = 1'b1;
      default: isMapped = 1'b0;
    endcase
    // values above 1 are out of range for both command objects
    writeOk = isMapped && !isReadOnly && (objWriteData[31:1] == 31'h0);
  end
  // command objects: store, act next cycle, then fall back to zero
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      restartCmd <= `SMAP_CMD_NONE;
      faultClearCmd <= `SMAP_CMD_NONE;
      restartTrigger <= 1'b0;
      faultDisplayClear <= 1'b0;
      restartRefused <= 1'b0;
      faultClearRefused <= 1'b0;
    end
    else
    begin
      restartTrigger <= 1'b0;
      faultDisplayClear <= 1'b0;
      restartRefused <= 1'b0;
      faultClearRefused <= 1'b0;
      if (restartCmd == `SMAP_CMD_ENABLE)
      begin
        // accepted or refused, the object clears itself
        restartTrigger <= restartAllowed;
        restartRefused <= !restartAllowed;
        restartCmd <= `SMAP_CMD_NONE;
      end
      if (faultClearCmd == `SMAP_CMD_ENABLE)
      begin
        // only the display flag moves; parameters stay untouched
        faultDisplayClear <= faultClearAllowed;
        faultClearRefused <= !faultClearAllowed;
        faultClearCmd <= `SMAP_CMD_NONE;
      end
      if (objWrite && writeOk)
      begin
        if (objIndex == `SMAP_OFS_RESTART_CMD)
        begin
          restartCmd <= objWriteData[15:0]; // writing 0 is a no-op
        end
        else
        begin
          faultClearCmd <= objWriteData[15:0];
        end
      end
    end
  end
  // fault display: a new fault wins over a clear in the same cycle
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      faultDisplayed <= 1'b0;
    end
    // a clear aimed at a dark display must not hide a fault that just came
    else if (faultPresent && !faultDisplayed)
    begin
      faultDisplayed <= 1'b1;
    end
    else if (faultDisplayClear)
    begin
      faultDisplayed <= 1'b0;
    end
  end
  // corrupt parameter location follows its source while the integrity fault
  // stands, and keeps the last location once the fault has gone
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      heldBadGroup <= 16'h0000;
      heldBadOffset <= 16'h0000;
    end
    else if (parameter_integrity_fault)
    begin
      heldBadGroup <= badParamGroup;
      heldBadOffset <= badParamOffset;
    end
  end
  // read mux: one value per object, registered only when a read is taken
  always @*
  begin
    next_readData = 32'h00000000;
    case (objIndex)
      `SMAP_OFS_ENTRY_COUNT:
      begin
        // fixed number of sub-objects in the auxiliary group
        next_readData = {24'h000000, `SMAP_RST_ENTRY_COUNT};
      end
      `SMAP_OFS_RESTART_CMD:
      begin
        // 16-bit objects sit in the low half, upper half zero
        next_readData = {16'h0000, restartCmd};
      end
      `SMAP_OFS_FAULT_CLEAR_CMD:
      begin
        // reads one for a single cycle at most, then zero again
        next_readData = {16'h0000, faultClearCmd};
      end
      `SMAP_OFS_ABS_POS_HIGH:
      begin
        // live value; the encoder side owns its timing
        next_readData = absPositionHigh;
      end
      `SMAP_OFS_LOAD_POS_LOW:
      begin
        // frozen outside rotation mode
        next_readData = heldLoadLow;
      end
      `SMAP_OFS_LOAD_POS_HIGH:
      begin
        next_readData = heldLoadHigh;
      end
      `SMAP_OFS_LOAD_POS_REF:
      begin
        next_readData = heldLoadRef;
      end
      `SMAP_OFS_BAD_GROUP:
      begin
        // group of the last corrupt parameter seen
        next_readData = {16'h0000, heldBadGroup};
      end
      `SMAP_OFS_BAD_OFFSET:
      begin
        // offset of that parameter inside its group
        next_readData = {16'h0000, heldBadOffset};
      end
      default:
      begin
        // unmapped: the error flag tells the host, data stay zero
        next_readData = 32'h00000000;
      end
    endcase
  end
  // access answer: one cycle after the request, with error for bad cases
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      objReadData <= 32'h00000000;
      objAck <= 1'b0;
      objError <= 1'b0;
    end
    else
    begin
      objAck <= objWrite || objRead;
      objError <= 1'b0;
      if (objWrite)
      begin
        objError <= !writeOk;
      end
      else if (objRead)
      begin
        // unmapped indexes answer zero data together with an error
        objError <= !isMapped;
        objReadData <= next_readData;
      end
    end
  end
endmodule
`default_nettype wire

//--- smap_regs.vh
// register offsets, field values and reset values of the monitor and auxiliary bank
`ifndef SMAP_REGS_VH
`define SMAP_REGS_VH
`define SMAP_OFS_ENTRY_COUNT 8'h00
`define SMAP_OFS_RESTART_CMD 8'h01
`define SMAP_OFS_FAULT_CLEAR_CMD 8'h02
`define SMAP_OFS_ABS_POS_HIGH 8'h50
`define SMAP_OFS_LOAD_POS_LOW 8'h52
`define SMAP_OFS_LOAD_POS_HIGH 8'h54
`define SMAP_OFS_LOAD_POS_REF 8'h56
`define SMAP_OFS_BAD_GROUP 8'h5b
`define SMAP_OFS_BAD_OFFSET 8'h5c
`define SMAP_RST_ENTRY_COUNT 8'h15
`define SMAP_RST_LOAD_POS_LOW 32'h00000001
`define SMAP_CMD_NONE 16'h0000
`define SMAP_CMD_ENABLE 16'h0001
`define SMAP_MODE_ROTATION 16'h0002
`define SMAP_STORE_BUSY 16'h0001
`define SMAP_CLASS_NONE 2'h0
`define SMAP_CLASS_ONE 2'h1
`define SMAP_CLASS_TWO 2'h2
`define SMAP_CLASS_WARN 2'h3
`define SMAP_RESTART_PULSE_CYCLES 4'h4
`endif

//--- smap_mon_hold.v
// latched copy of one monitor word, refreshed only while its gate is open
`timescale 1ns/10ps
`default_nettype none
module smap_mon_hold #(
  parameter WIDTH = 32,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clk_sys,
  input wire rst,
  input wire gate,
  input wire [WIDTH-1:0] liveValue,
  output reg [WIDTH-1:0] heldValue
);
  // the gate keeps a stale value rather than garbage when the mode is wrong
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      heldValue <= RESET_VALUE;
    end
    else if (gate)
    begin
      heldValue <= liveValue;
    end
  end
endmodule
`default_nettype wire

//--- smap_pulse_gen.v
// stretches a one-cycle trigger into a fixed-length action pulse
`timescale 1ns/10ps
`default_nettype none
module smap_pulse_gen #(
  parameter [3:0] LENGTH = 4'h4
) (
  input wire clk_sys,
  input wire rst,
  input wire trigger,
  output wire pulseOut
);
  reg [3:0] remaining; // cycles left in the pulse
  // a retrigger during the pulse restarts the count
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      remaining <= 4'h0;
    end
    else if (trigger)
    begin
      remaining <= LENGTH;
    end
    else if (remaining != 4'h0)
    begin
      remaining <= remaining - 4'h1;
    end
  end
  assign pulseOut = (remaining != 4'h0);
endmodule
`default_nettype wire

//--- smap_asserts.sv
// concurrent checks on the object bank ports
`timescale 1ns/10ps
`default_nettype none
module smap_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic objWrite,
  input wire logic objRead,
  input wire logic [7:0] objIndex,
  input wire logic [31:0] objWriteData,
  input wire logic objAck,
  input wire logic objError,
  input wire logic servoOn,
  input wire logic driveOperational,
  input wire logic [15:0] storageSetting,
  input wire logic faultPresent,
  input wire logic [1:0] faultClass,
  input wire logic faultNonResettable,
  input wire logic restartRequest,
  input wire logic restartRefused,
  input wire logic faultDisplayClear,
  input wire logic faultClearRefused
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // command writes of value one, conditions are judged one edge later
  wire logic rstWr = objWrite && objIndex == 8'h01 && objWriteData == 32'h1;
  wire logic clrWr = objWrite && objIndex == 8'h02 && objWriteData == 32'h1;
  wire logic lock1 = faultPresent && faultNonResettable && faultClass == 2'h1;
  a_ack_next: assert property ((objWrite || objRead) |=> objAck) else $error("no ack");
  a_ro_write: assert property (objWrite && objIndex == 8'h52 |=> objError)
    else $error("read-only write accepted");
  a_bad_value: assert property (objWrite && objIndex == 8'h01 && objWriteData > 32'h1 |=> objError)
    else $error("out of range accepted");
  a_restart_len: assert property ($rose(restartRequest) |-> restartRequest [*4] ##1 !restartRequest)
    else $error("restart pulse length");
  a_restart_ok: assert property (rstWr ##1 (!servoOn && storageSetting != 16'h1 && !lock1) |-> ##2 restartRequest)
    else $error("restart not started");
  a_restart_block: assert property (rstWr ##1 (servoOn || storageSetting == 16'h1 || lock1) |=> restartRefused ##1 !$rose(restartRequest))
    else $error("restart not refused");
  a_clear_run: assert property (clrWr ##1 (driveOperational && faultPresent && !faultNonResettable && faultClass != 2'h3) |=> faultClearRefused && !faultDisplayClear)
    else $error("clear while running");
  a_clear_warn: assert property (clrWr ##1 (faultPresent && !faultNonResettable && faultClass == 2'h3) |=> faultDisplayClear)
    else $error("warning not cleared");
  a_nonres_kept: assert property (clrWr ##1 (faultPresent && faultNonResettable) |=> !faultDisplayClear)
    else $error("non-resettable cleared");
endmodule
`default_nettype wire

//--- smap_host.sv
// host model: one object access at a time over the dictionary port
`timescale 1ns/10ps
`default_nettype none
module smap_host (
  input wire logic clk_sys,
  input wire logic objAck,
  input wire logic objError,
  input wire logic [31:0] objReadData,
  output logic objWrite,
  output logic objRead,
  output logic [7:0] objIndex,
  output logic [31:0] objWriteData
);
  initial
  begin
    objWrite = 1'b0;
    objRead = 1'b0;
    objIndex = 8'h00;
    objWriteData = 32'h0;
  end
  // request at a falling edge, answer taken one cycle later
  task automatic access(input logic wr, input logic [7:0] idx, input logic [31:0] dat,
                        output logic [31:0] rd, output logic er);
    @(negedge clk_sys);
    objWrite = wr;
    objRead = !wr;
    objIndex = idx;
    objWriteData = dat;
    @(negedge clk_sys);
    objWrite = 1'b0;
    objRead = 1'b0;
    // released data shows the inverse so stale values never look valid
    objWriteData = ~dat;
    rd = objReadData;
    // a missing answer poisons the error flag so any check of the flag fails
    er = (objAck === 1'b1) ? objError : 1'bx;
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the monitor and auxiliary object bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module tb;
  typedef struct {logic wr; logic [7:0] idx; logic [31:0] dat; logic [31:0] exp; logic err;} smap_row_t;
  logic clk_sys = 1'b0, rst = 1'b1, servoOn = 1'b0, driveOperational = 1'b0, faultPresent = 1'b0;
  logic faultNonResettable = 1'b0, parameter_integrity_fault = 1'b0, er;
  logic [15:0] positionMode = 16'h0, storageSetting = 16'h0;
  logic [1:0] faultClass = 2'h0;
  logic [31:0] absPositionHigh = 32'ha5a50050, loadPositionLow = 32'h11110052;
  logic [31:0] loadPositionHigh = 32'h22220054, loadPositionRef = 32'h33330056, rd;
  wire logic objWrite, objRead, objAck, objError, restartRequest, faultDisplayClear;
  wire logic faultDisplayed, restartRefused, faultClearRefused;
  wire logic [7:0] objIndex;
  wire logic [31:0] objWriteData, objReadData;
  int failures = 0, n_checks = 0;
  // reads of every object but the fault clear command and of one unmapped index, then refused writes and a harmless zero write
  smap_row_t rows [14] = '{'{0, 8'h00, 0, 32'h15, 0}, '{0, 8'h50, 0, 32'ha5a50050, 0},
    '{0, 8'h52, 0, 32'h11110052, 0}, '{0, 8'h54, 0, 32'h22220054, 0},
    '{0, 8'h56, 0, 32'h33330056, 0}, '{0, 8'h5b, 0, 32'h200a, 0}, '{0, 8'h5c, 0, 32'h4, 0},
    '{0, 8'h01, 0, 32'h0, 0}, '{0, 8'h33, 0, 0, 1}, '{1, 8'h52, 1, 0, 1}, '{1, 8'h00, 5, 0, 1},
    '{1, 8'h01, 2, 0, 1}, '{1, 8'h02, 32'h10001, 0, 1}, '{1, 8'h01, 0, 0, 0}};
  always #2.5 clk_sys = ~clk_sys;
  smap_host i_host (.clk_sys, .objAck, .objError, .objReadData, .objWrite, .objRead, .objIndex,
    .objWriteData);
  smap_servo_monitor_aux i_dut (.clk_sys, .rst, .objWrite, .objRead, .objIndex, .objWriteData,
    .objReadData, .objAck, .objError, .servoOn, .driveOperational, .positionMode, .storageSetting,
    .faultPresent, .faultClass, .faultNonResettable, .absPositionHigh, .loadPositionLow,
    .loadPositionHigh, .loadPositionRef, .parameter_integrity_fault, .badParamGroup(16'h200a),
    .badParamOffset(16'h0004), .restartRequest, .faultDisplayClear, .faultDisplayed,
    .restartRefused, .faultClearRefused);
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // restart command; the verdict shows first, an accepted request a cycle later for four cycles
  task automatic restart(input logic e);
    i_host.access(1, 8'h01, 32'h1, rd, er);
    @(negedge clk_sys);
    `CHK(restartRefused, !e)
    repeat (4)
    begin
      @(negedge clk_sys);
      `CHK(restartRequest, e)
    end
    @(negedge clk_sys);
    `CHK(restartRequest, 1'b0)
  endtask
  // fault clear command, outcome one cycle after the answer
  task automatic clear(input logic e);
    i_host.access(1, 8'h02, 32'h1, rd, er);
    @(negedge clk_sys);
    `CHK({faultDisplayClear, faultClearRefused}, {e, !e})
  endtask
  initial
  begin
    #60000;
    failures++;
    tally_and_finish;
  end
  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    i_host.access(0, 8'h52, 0, rd, er);
    `CHK(rd, 32'h1)
    positionMode = 16'h2;
    parameter_integrity_fault = 1'b1;
    foreach (rows[i])
    begin
      i_host.access(rows[i].wr, rows[i].idx, rows[i].dat, rd, er);
      `CHK(er, rows[i].err)
      if (!rows[i].wr && !rows[i].err) `CHK(rd, rows[i].exp)
    end
    // leaving rotation mode freezes the load position
    positionMode = 16'h0;
    loadPositionLow = 32'h0;
    i_host.access(0, 8'h52, 0, rd, er);
    `CHK(rd, 32'h11110052)
    servoOn = 1'b1;
    restart(0);
    servoOn = 1'b0;
    storageSetting = 16'h1;
    restart(0);
    storageSetting = 16'h0;
    {faultPresent, faultClass, faultNonResettable} = 4'hb;
    restart(0);
    clear(0);
    {faultNonResettable, driveOperational} = 2'h1;
    clear(0);
    driveOperational = 1'b0;
    clear(1);
    @(negedge clk_sys);
    `CHK(faultDisplayed, 1'b0)
    {faultClass, driveOperational} = 3'h7;
    clear(1);
    {faultPresent, driveOperational} = 2'h0;
    restart(1);
    i_host.access(0, 8'h01, 0, rd, er);
    `CHK(rd, 32'h0)
    i_host.access(0, 8'h02, 0, rd, er);
    `CHK(rd, 32'h0)
    tally_and_finish;
  end
endmodule
bind smap_servo_monitor_aux smap_asserts i_chk (.clk_sys, .rst, .objWrite, .objRead, .objIndex,
  .objWriteData, .objAck, .objError, .servoOn, .driveOperational, .storageSetting, .faultPresent,
  .faultClass, .faultNonResettable, .restartRequest, .restartRefused, .faultDisplayClear,
  .faultClearRefused);
`default_nettype wire
